/* verilog/pairable_timer_pkg.sv */
// Constants, register map and carrier types for the pairable 32-bit timer.
package pairable_timer_pkg;

   // ==========================================================================
   // Register byte offsets on the Avalon-MM slave.
   // ==========================================================================
   localparam logic [4:0] LOWER_CONTROL_OFFSET = 5'h00;
   localparam logic [4:0] UPPER_CONTROL_OFFSET = 5'h04;
   localparam logic [4:0] LOWER_COUNT_OFFSET = 5'h08;
   localparam logic [4:0] UPPER_COUNT_OFFSET = 5'h0c;
   localparam logic [4:0] LOWER_PERIOD_OFFSET = 5'h10;
   localparam logic [4:0] UPPER_PERIOD_OFFSET = 5'h14;

   // ==========================================================================
   // Control register field positions.
   // ==========================================================================
   localparam int TIMER_ON_BIT = 15;
   localparam int IDLE_STOP_BIT = 13;
   localparam int GATE_ACCUMULATE_BIT = 6;
   localparam int PRESCALE_HI_BIT = 5;
   localparam int PRESCALE_LO_BIT = 4;
   localparam int PAIR_JOIN_BIT = 3;
   localparam int CLOCK_SOURCE_BIT = 1;

   // Writable bits; every other position ignores writes and reads as zero.
   localparam logic [15:0] LOWER_CONTROL_MASK = 16'ha07a;
   localparam logic [15:0] UPPER_CONTROL_MASK = 16'ha072;

   // ==========================================================================
   // Reset values.
   // ==========================================================================
   localparam logic [15:0] CONTROL_RESET = 16'h0000;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] PERIOD_RESET = 16'hffff;
   localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

   // ==========================================================================
   // Prescaler encodings and the terminal counts of the divider.
   // ==========================================================================
   localparam logic [1:0] PRESCALE_DIV1 = 2'h0;
   localparam logic [1:0] PRESCALE_DIV8 = 2'h1;
   localparam logic [1:0] PRESCALE_DIV64 = 2'h2;
   localparam logic [1:0] PRESCALE_DIV256 = 2'h3;
   localparam logic [7:0] PRESCALE_LIMIT_DIV1 = 8'h00;
   localparam logic [7:0] PRESCALE_LIMIT_DIV8 = 8'h07;
   localparam logic [7:0] PRESCALE_LIMIT_DIV64 = 8'h3f;
   localparam logic [7:0] PRESCALE_LIMIT_DIV256 = 8'hff;

   // ==========================================================================
   // Carrier types.
   // ==========================================================================
   typedef struct packed {
      logic [4:0] address;
      logic read;
      logic write;
      logic [3:0] byteenable;
      logic [31:0] writedata;
   } avmm_req_t;

   typedef struct packed {
      logic [15:0] upper;
      logic [15:0] lower;
   } count_pair_t;

endpackage : pairable_timer_pkg

/* verilog/pairable_timer_32bit.sv */
// Timer pair that runs as two 16-bit timers or one 32-bit timer/counter.
//
// Contract
// - The pair works as one 32-bit timer or two separate 16-bit timers.
// - Separate 16-bit timers offer all modes except asynchronous counting.
// - Each 16-bit timer runs as synchronous timer or synchronous counter.
// - In 32-bit mode only the lower control register steers the pair.
// - 32-bit mode uses the lower clock and gate; upper raises the event.
// - 32-bit mode raises its event when count matches the 32-bit period.
// - Upper period register is the high word, lower the low word.
// - Count pair reads upper as high word and lower as low word.
// - Lower on bit starts the pair when joined, else only the lower timer.
// - Pair join bit 3 joins both timers into one 32-bit timer.
// - Idle stop bit set halts the timer while the device is idle.
// - Gate accumulation bit is ignored with external clock selected.
// - Prescale field divides the input clock by 1, 8, 64 or 256.
// - Clock source bit selects external rising edges or instruction clock.
// - Unimplemented control bits ignore writes and read as zero.
// - First pair triggers the first ADC, second pair the second ADC.
// - Only the first pair supplies its counts as capture/compare time bases.
// - Event on period match or on gate falling edge in gated mode.
//
// Chosen here: register access over Avalon-MM and the address map.
`timescale 1ns/1ps

module pairable_timer_32bit
   import pairable_timer_pkg::*;
#(
   parameter int PAIR_INDEX = 1
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire avmm_req_t avmm_req_i,
   output logic waitrequest_o,
   output logic [31:0] readdata_o,
   input wire logic idle_mode_i,
   input wire logic lower_ext_clock_pin_i,
   input wire logic upper_ext_clock_pin_i,
   output logic lower_event_o,
   output logic upper_event_o,
   output logic adc1_trigger_o,
   output logic adc2_trigger_o,
   output count_pair_t time_base_o
);

   // ==========================================================================
   // Decoding helpers.
   // ==========================================================================

   // Terminal count of the prescaler for a given prescale_select code.
   function automatic logic [7:0] prescale_limit(input logic [1:0] prescale_select);
      logic [7:0] limit;
      limit = PRESCALE_LIMIT_DIV1;
      case (prescale_select)
         PRESCALE_DIV8: limit = PRESCALE_LIMIT_DIV8;
         PRESCALE_DIV64: limit = PRESCALE_LIMIT_DIV64;
         PRESCALE_DIV256: limit = PRESCALE_LIMIT_DIV256;
         default: limit = PRESCALE_LIMIT_DIV1;
      endcase
      return limit;
   endfunction : prescale_limit

   // Merges a 16-bit write into a register, honouring the two low byte lanes.
   function automatic logic [15:0] merge_lanes(input logic [15:0] old_value,
                                               input logic [31:0] wdata,
                                               input logic [3:0] byteenable);
      logic [15:0] merged;
      merged = old_value;
      if (byteenable[0]) begin
         merged[7:0] = wdata[7:0];
      end
      if (byteenable[1]) begin
         merged[15:8] = wdata[15:8];
      end
      return merged;
   endfunction : merge_lanes

   // ==========================================================================
   // Storage.
   // ==========================================================================
   logic [15:0] control [2];
   logic [15:0] count [2];
   logic [15:0] period [2];
   logic [7:0] prescale_count [2];
   logic pin_meta [2];
   logic pin_sync [2];
   logic pin_prev [2];

   // ==========================================================================
   // Bus decode.
   // ==========================================================================
   wire logic write_now;
   wire logic read_now;
   wire logic [15:0] control_mask [2];
   wire logic [4:0] control_offset [2];
   wire logic [4:0] count_offset [2];
   wire logic [4:0] period_offset [2];
   wire logic [31:0] read_word;

   // A write takes effect only at the edge where the master sees waitrequest low.
   assign write_now = avmm_req_i.write & ~waitrequest_o;
   assign read_now = avmm_req_i.read & waitrequest_o;
   assign control_mask[0] = LOWER_CONTROL_MASK;
   assign control_mask[1] = UPPER_CONTROL_MASK;
   assign control_offset[0] = LOWER_CONTROL_OFFSET;
   assign control_offset[1] = UPPER_CONTROL_OFFSET;
   assign count_offset[0] = LOWER_COUNT_OFFSET;
   assign count_offset[1] = UPPER_COUNT_OFFSET;
   assign period_offset[0] = LOWER_PERIOD_OFFSET;
   assign period_offset[1] = UPPER_PERIOD_OFFSET;

   logic [31:0] read_word_c;

   // Read mux; upper words read as zero and unmapped addresses return zero.
   always_comb begin
      unique case (avmm_req_i.address)
         LOWER_CONTROL_OFFSET: read_word_c = {16'h0000, control[0]};
         UPPER_CONTROL_OFFSET: read_word_c = {16'h0000, control[1]};
         LOWER_COUNT_OFFSET: read_word_c = {16'h0000, count[0]};
         UPPER_COUNT_OFFSET: read_word_c = {16'h0000, count[1]};
         LOWER_PERIOD_OFFSET: read_word_c = {16'h0000, period[0]};
         UPPER_PERIOD_OFFSET: read_word_c = {16'h0000, period[1]};
         default: read_word_c = READ_UNMAPPED;
      endcase
   end
   assign read_word = read_word_c;

   // ==========================================================================
   // Bus handshake: every request waits exactly one cycle, then is answered.
   // ==========================================================================
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         waitrequest_o <= 1'b1;
         readdata_o <= READ_UNMAPPED;
      end else begin
         waitrequest_o <= ~((avmm_req_i.read | avmm_req_i.write) & waitrequest_o);
         if (read_now) begin
            readdata_o <= read_word;
         end
      end
   end

   // ==========================================================================
   // Mode decode.
   // ==========================================================================
   wire logic pair_join;
   wire logic [15:0] active_control [2];

   // In 32-bit mode the upper control bits are ignored entirely.
   assign pair_join = control[0][PAIR_JOIN_BIT];
   assign active_control[0] = control[0];
   assign active_control[1] = pair_join ? control[0] : control[1];

   // ==========================================================================
   // Per-timer clocking: pin synchroniser, source select, gate and prescaler.
   // ==========================================================================
   wire logic ext_pin [2];
   wire logic timer_on [2];
   wire logic running [2];
   wire logic ext_selected [2];
   wire logic gated [2];
   wire logic raw_tick [2];
   wire logic [7:0] limit [2];
   wire logic tick [2];
   wire logic gate_fall [2];
   wire logic match16 [2];
   wire logic [15:0] next_count16 [2];

   // The upper pin is also sampled in 32-bit mode; only the upper prescaler, whose tick is unused, reads it then.
   assign ext_pin[0] = lower_ext_clock_pin_i;
   assign ext_pin[1] = upper_ext_clock_pin_i;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_timer
         // Pins are asynchronous, so they pass two flops before any logic.
         always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               pin_meta[gi] <= 1'b0;
               pin_sync[gi] <= 1'b0;
               pin_prev[gi] <= 1'b0;
            end else begin
               pin_meta[gi] <= ext_pin[gi];
               pin_sync[gi] <= pin_meta[gi];
               pin_prev[gi] <= pin_sync[gi];
            end
         end

         // Idle stop freezes the timer but keeps its count and prescale state.
         assign timer_on[gi] = active_control[gi][TIMER_ON_BIT];
         assign running[gi] = timer_on[gi] &
            ~(active_control[gi][IDLE_STOP_BIT] & idle_mode_i);
         assign ext_selected[gi] = active_control[gi][CLOCK_SOURCE_BIT];
         // Gate accumulation is forced off when the external clock is chosen.
         assign gated[gi] = ~ext_selected[gi] &
            active_control[gi][GATE_ACCUMULATE_BIT];
         // External clocking is synchronous: rising edges are found in clk_i.
         assign raw_tick[gi] = ext_selected[gi] ? (pin_sync[gi] & ~pin_prev[gi]) :
            (gated[gi] ? pin_sync[gi] : 1'b1);
         assign limit[gi] = prescale_limit(
            active_control[gi][PRESCALE_HI_BIT:PRESCALE_LO_BIT]);
         assign tick[gi] = running[gi] & raw_tick[gi] &
            (prescale_count[gi] == limit[gi]);
         assign gate_fall[gi] = running[gi] & gated[gi] &
            pin_prev[gi] & ~pin_sync[gi];
         assign match16[gi] = count[gi] == period[gi];
         assign next_count16[gi] = match16[gi] ? COUNT_RESET :
            count[gi] + 16'h0001;

         // Prescaler: cleared while stopped so each start divides from zero.
         always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               prescale_count[gi] <= 8'h00;
            end else if (!timer_on[gi]) begin
               prescale_count[gi] <= 8'h00;
            end else if (running[gi] & raw_tick[gi]) begin
               prescale_count[gi] <= (prescale_count[gi] == limit[gi]) ? 8'h00 :
                  prescale_count[gi] + 8'h01;
            end
         end

         // Control and period registers; reserved positions are masked.
         always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               control[gi] <= CONTROL_RESET;
               period[gi] <= PERIOD_RESET;
            end else if (write_now) begin
               if (avmm_req_i.address == control_offset[gi]) begin
                  control[gi] <= merge_lanes(control[gi], avmm_req_i.writedata,
                     avmm_req_i.byteenable) & control_mask[gi];
               end
               if (avmm_req_i.address == period_offset[gi]) begin
                  period[gi] <= merge_lanes(period[gi], avmm_req_i.writedata,
                     avmm_req_i.byteenable);
               end
            end
         end
      end
   endgenerate

   // ==========================================================================
   // Counting: one 32-bit count in joined mode, two 16-bit counts otherwise.
   // ==========================================================================
   wire logic [31:0] count32;
   wire logic [31:0] period32;
   wire logic match32;
   wire logic [31:0] next_count32;
   wire logic load_count [2];

   assign count32 = {count[1], count[0]};
   assign period32 = {period[1], period[0]};
   assign match32 = count32 == period32;
   assign next_count32 = match32 ? 32'h0000_0000 : count32 + 32'h0000_0001;
   assign load_count[0] = write_now & (avmm_req_i.address == count_offset[0]);
   assign load_count[1] = write_now & (avmm_req_i.address == count_offset[1]);

   // A software load wins over a tick in the same cycle; only the loaded word drops the tick.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         count[0] <= COUNT_RESET;
         count[1] <= COUNT_RESET;
      end else begin
         if (load_count[0]) begin
            count[0] <= merge_lanes(count[0], avmm_req_i.writedata, avmm_req_i.byteenable);
         end else if (pair_join & tick[0]) begin
            count[0] <= next_count32[15:0];
         end else if (!pair_join & tick[0]) begin
            count[0] <= next_count16[0];
         end
         if (load_count[1]) begin
            count[1] <= merge_lanes(count[1], avmm_req_i.writedata, avmm_req_i.byteenable);
         end else if (pair_join & tick[0]) begin
            count[1] <= next_count32[31:16];
         end else if (!pair_join & tick[1]) begin
            count[1] <= next_count16[1];
         end
      end
   end

   // ==========================================================================
   // Events, ADC triggers and time bases.
   // ==========================================================================
   wire logic next_lower_event;
   wire logic next_upper_event;
   wire logic next_pair_match;
   wire logic first_pair;
   wire logic second_pair;

   // Joined mode reports through the upper event only, driven by lower inputs.
   assign next_lower_event = ~pair_join & ((tick[0] & match16[0]) | gate_fall[0]);
   assign next_upper_event = pair_join ?
      ((tick[0] & match32) | gate_fall[0]) :
      ((tick[1] & match16[1]) | gate_fall[1]);
   // The ADC trigger follows period matches only, not gate falling edges.
   assign next_pair_match = pair_join ? (tick[0] & match32) : (tick[0] & match16[0]);
   assign first_pair = PAIR_INDEX == 1;
   assign second_pair = PAIR_INDEX == 2;

   // Every output is a flop, so events rise at the same edge as the counter wrap.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lower_event_o <= 1'b0;
         upper_event_o <= 1'b0;
         adc1_trigger_o <= 1'b0;
         adc2_trigger_o <= 1'b0;
         time_base_o <= '0;
      end else begin
         lower_event_o <= next_lower_event;
         upper_event_o <= next_upper_event;
         adc1_trigger_o <= first_pair & next_pair_match;
         adc2_trigger_o <= second_pair & next_pair_match;
         if (first_pair) begin
            time_base_o <= {count[1], count[0]};
         end else begin
            time_base_o <= '0;
         end
      end
   end

endmodule : pairable_timer_32bit

/* sim/pairable_timer_32bit_props.sv */
// Port checker for the pairable 32-bit timer.
`timescale 1ns/1ps

// ============================================================================
// Checker.
module pairable_timer_32bit_props
   import pairable_timer_pkg::*;
#(
   parameter int PAIR_INDEX = 1
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire avmm_req_t avmm_req_i,
   input wire logic waitrequest_o,
   input wire logic [31:0] readdata_o,
   input wire logic idle_mode_i,
   input wire logic lower_event_o,
   input wire logic upper_event_o,
   input wire logic adc1_trigger_o,
   input wire logic adc2_trigger_o,
   input wire count_pair_t time_base_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   logic [15:0] ctl;
   logic [1:0] steady;
   // Bus decodes and the settled-mode condition used by the prescale check.
   wire acc_wr = avmm_req_i.write && !waitrequest_o;
   wire ctl_wr = acc_wr && (avmm_req_i.address == LOWER_CONTROL_OFFSET);
   wire ctl_rd = avmm_req_i.read && !waitrequest_o && (avmm_req_i.address[4:3] == 2'h0);
   wire run8 = ctl[TIMER_ON_BIT] && (ctl[5:4] == PRESCALE_DIV8) && !ctl[CLOCK_SOURCE_BIT] &&
      !ctl[GATE_ACCUMULATE_BIT] && (steady == 2'h3) && !idle_mode_i;

   // Shadow of the lower control word. Every accepted write restarts the settle count, so a
   // count load or a mode change in flight is never taken for a runaway timer.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctl <= 16'h0000;
         steady <= 2'h0;
      end else begin
         if (ctl_wr) begin
            ctl <= avmm_req_i.writedata[15:0] & LOWER_CONTROL_MASK;
         end
         steady <= acc_wr ? 2'h0 : ((steady == 2'h3) ? steady : steady + 2'h1);
      end
   end

   property p_wait_answer;
      (avmm_req_i.read || avmm_req_i.write) && waitrequest_o |=> !waitrequest_o;
   endproperty
   a_wait_answer: assert property (p_wait_answer) else $error("waitrequest late");
   property p_wait_stands;
      !waitrequest_o |=> waitrequest_o;
   endproperty
   a_wait_stands: assert property (p_wait_stands) else $error("waitrequest low too long");
   property p_ctl_rsvd;
      ctl_rd |-> (readdata_o[31:16] == 16'h0000) && ((readdata_o[15:0] &
         ~(avmm_req_i.address[2] ? UPPER_CONTROL_MASK : LOWER_CONTROL_MASK)) == 16'h0000);
   endproperty
   a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("reserved bit set");
   property p_adc2_quiet;
      (PAIR_INDEX != 2) |-> !adc2_trigger_o;
   endproperty
   a_adc2_quiet: assert property (p_adc2_quiet) else $error("stray adc2 trigger");
   property p_adc1_cause;
      adc1_trigger_o |-> (PAIR_INDEX == 1) && (upper_event_o || lower_event_o);
   endproperty
   a_adc1_cause: assert property (p_adc1_cause) else $error("adc1 without match");
   property p_joined_quiet;
      ctl[PAIR_JOIN_BIT] && (steady == 2'h3) |-> !lower_event_o;
   endproperty
   a_joined_quiet: assert property (p_joined_quiet) else $error("lower event joined");
   property p_off_frozen;
      !ctl[TIMER_ON_BIT] && (steady == 2'h3) |=> $stable(time_base_o.lower);
   endproperty
   a_off_frozen: assert property (p_off_frozen) else $error("count moved while off");
   property p_idle_frozen;
      idle_mode_i [*3] ##0 (ctl[IDLE_STOP_BIT] && (steady == 2'h3)) |=>
         $stable(time_base_o.lower);
   endproperty
   a_idle_frozen: assert property (p_idle_frozen) else $error("count moved in idle");
   property p_div8;
      run8 && $changed(time_base_o.lower) |=> $stable(time_base_o.lower) [*7];
   endproperty
   a_div8: assert property (p_div8) else $error("divide by 8 too fast");
   property p_evt_pulse;
      upper_event_o |=> !upper_event_o;
   endproperty
   a_evt_pulse: assert property (p_evt_pulse) else $error("event longer than one");

   c_upper_event: cover property (upper_event_o);
   c_adc1: cover property (adc1_trigger_o);
   c_ctl_read: cover property (ctl_rd);
endmodule : pairable_timer_32bit_props

bind pairable_timer_32bit pairable_timer_32bit_props #(.PAIR_INDEX(PAIR_INDEX)) u_props (
   .clk_i(clk_i), .rst_b_i(rst_b_i), .avmm_req_i(avmm_req_i), .waitrequest_o(waitrequest_o),
   .readdata_o(readdata_o), .idle_mode_i(idle_mode_i), .lower_event_o(lower_event_o),
   .upper_event_o(upper_event_o), .adc1_trigger_o(adc1_trigger_o),
   .adc2_trigger_o(adc2_trigger_o), .time_base_o(time_base_o));

/* sim/ext_pin_source.sv */
// External clock and gate source for the lower timer pin.
`timescale 1ns/1ps

// ============================================================================
// Pin source model.
module ext_pin_source (
   input wire logic clk_i,
   input wire logic start_i,
   input wire logic hold_i,
   input wire logic [7:0] n_i,
   output logic pin_o
);
   int left;
   // Pulse mode sends n_i rising edges, three cycles high and three low. Hold mode keeps the
   // gate high for n_i cycles. The pin rests low between bursts, as an idle source does.
   always @(posedge clk_i) begin
      if (start_i) begin
         left <= hold_i ? n_i : n_i * 6;
      end else if (left > 0) begin
         left <= left - 1;
      end
   end
   assign pin_o = (left > 0) && (hold_i || ((left - 1) % 6 >= 3));
endmodule : ext_pin_source

/* sim/pairable_timer_32bit_tb.sv */
// Self-checking bench for the pairable 32-bit timer.
`timescale 1ns/1ps

// ============================================================================
// Bench top.
module pairable_timer_32bit_tb
   import pairable_timer_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic idle_mode_i = 1'b0;
   logic start = 1'b0;
   logic hold = 1'b0;
   logic [7:0] n_edges = 8'h00;
   avmm_req_t req = '0;
   logic waitrequest_o, lower_event_o, upper_event_o, adc1_trigger_o, adc2_trigger_o, pin;
   logic [31:0] readdata_o, q, c;
   count_pair_t time_base_o;
   int n_fail = 0;
   int n_tests = 0;
   int n;
   int dv [4] = '{1, 8, 64, 256};
   logic [4:0] ra [8] = '{LOWER_CONTROL_OFFSET, UPPER_CONTROL_OFFSET, LOWER_CONTROL_OFFSET,
      UPPER_CONTROL_OFFSET, LOWER_PERIOD_OFFSET, UPPER_PERIOD_OFFSET, 5'h18, LOWER_PERIOD_OFFSET};
   logic [31:0] rw [8] = '{32'hffff, 32'hffff, 32'h0, 32'h0, 32'h1234, 32'habcd, 32'hffff,
      32'hffff_0005};
   logic [31:0] re [8] = '{{16'h0000, LOWER_CONTROL_MASK}, {16'h0000, UPPER_CONTROL_MASK},
      32'h0, 32'h0, 32'h1234, 32'habcd, 32'h0, 32'h5};

   always #2.5 clk_i = ~clk_i;

   pairable_timer_32bit u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .avmm_req_i(req),
      .waitrequest_o(waitrequest_o), .readdata_o(readdata_o), .idle_mode_i(idle_mode_i),
      .lower_ext_clock_pin_i(pin), .upper_ext_clock_pin_i(1'b0), .lower_event_o(lower_event_o),
      .upper_event_o(upper_event_o), .adc1_trigger_o(adc1_trigger_o),
      .adc2_trigger_o(adc2_trigger_o), .time_base_o(time_base_o));
   ext_pin_source u_src (.clk_i(clk_i), .start_i(start), .hold_i(hold), .n_i(n_edges),
      .pin_o(pin));

   // ==========================================================================
   // Tasks.
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   // One bus cycle; the request is held until waitrequest is seen low at an edge.
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_i);
      req <= '{address: a, read: !w, write: w, byteenable: 4'hf, writedata: d};
      do @(posedge clk_i); while (waitrequest_o !== 1'b0);
      q = readdata_o;
      req.read <= 1'b0;
      req.write <= 1'b0;
   endtask : bus

   task automatic wreg(input logic [4:0] a, input logic [15:0] d);
      bus(1'b1, a, {16'h0000, d});
   endtask : wreg

   task automatic rreg(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask : rreg

   // Counts cycles until the chosen event output is seen high.
   task automatic wait_ev(input logic w, output int m);
      m = 0;
      do begin
         @(posedge clk_i);
         m++;
      end while ((w ? upper_event_o : lower_event_o) !== 1'b1 && m < 70000);
   endtask : wait_ev

   task automatic pulse(input logic h, input logic [7:0] e);
      @(posedge clk_i);
      hold <= h;
      n_edges <= e;
      start <= 1'b1;
      @(posedge clk_i);
      start <= 1'b0;
   endtask : pulse

   task automatic final_report;
      $display("tests %0d fails %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report

   // ==========================================================================
   // Main sequence.
   initial begin
      repeat (3) @(posedge clk_i);
      rst_b_i <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         rreg(5'(i * 4), (i < 4) ? 32'h0 : 32'h0000_ffff);
      end
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, ra[i], rw[i]);
         rreg(ra[i], re[i]);
      end
      $display("test registers done");
      // Both halves run apart; the lower one steps through every divide ratio.
      wreg(LOWER_PERIOD_OFFSET, 16'h0002);
      wreg(UPPER_PERIOD_OFFSET, 16'h0004);
      wreg(UPPER_CONTROL_OFFSET, 16'h8000);
      wait_ev(1'b1, n);
      wait_ev(1'b1, n);
      chk(32'(n), 32'h5);
      for (int p = 0; p < 4; p++) begin
         wreg(LOWER_CONTROL_OFFSET, 16'h8000 | 16'(p << 4));
         wait_ev(1'b0, n);
         wait_ev(1'b0, n);
         chk(32'(n), 32'(3 * dv[p]));
      end
      wreg(UPPER_CONTROL_OFFSET, 16'h0000);
      $display("test prescale done");
      // External edges count; the gate bit set beside them must change nothing.
      wreg(LOWER_CONTROL_OFFSET, 16'h0000);
      wreg(LOWER_COUNT_OFFSET, 16'h0000);
      wreg(LOWER_PERIOD_OFFSET, 16'hffff);
      wreg(LOWER_CONTROL_OFFSET, 16'h8042);
      pulse(1'b0, 8'h05);
      repeat (40) @(posedge clk_i);
      rreg(LOWER_COUNT_OFFSET, 32'h5);
      // Gated accumulation counts while the gate is high and signals its fall.
      wreg(LOWER_CONTROL_OFFSET, 16'h0000);
      wreg(LOWER_COUNT_OFFSET, 16'h0000);
      wreg(LOWER_CONTROL_OFFSET, 16'h8040);
      pulse(1'b1, 8'h14);
      wait_ev(1'b0, n);
      chk(32'(n >= 18 && n <= 30), 32'h1);
      bus(1'b0, LOWER_COUNT_OFFSET, 32'h0);
      chk(32'(q >= 19 && q <= 21), 32'h1);
      // Idle with the stop bit set freezes the count; with it clear the count runs on.
      for (int s = 1; s >= 0; s--) begin
         wreg(LOWER_CONTROL_OFFSET, (s == 1) ? 16'ha000 : 16'h8000);
         idle_mode_i <= 1'b1;
         bus(1'b0, LOWER_COUNT_OFFSET, 32'h0);
         c = q;
         bus(1'b0, LOWER_COUNT_OFFSET, 32'h0);
         chk(32'(q == c), 32'(s));
         idle_mode_i <= 1'b0;
      end
      $display("test pins and idle done");
      // Joined pair; the upper control word is left off and must be ignored.
      wreg(LOWER_CONTROL_OFFSET, 16'h0008);
      wreg(UPPER_CONTROL_OFFSET, 16'h0030);
      wreg(LOWER_PERIOD_OFFSET, 16'h0010);
      wreg(UPPER_PERIOD_OFFSET, 16'h0001);
      for (int ph = 0; ph < 2; ph++) begin
         wreg(UPPER_COUNT_OFFSET, 16'h0000);
         wreg(LOWER_COUNT_OFFSET, 16'hfff8);
         wreg(LOWER_CONTROL_OFFSET, 16'h8008);
         if (ph == 0) begin
            repeat (12) @(posedge clk_i);
            wreg(LOWER_CONTROL_OFFSET, 16'h0008);
            rreg(UPPER_COUNT_OFFSET, 32'h1);
            chk(32'(time_base_o.upper), 32'h1);
         end else begin
            wait_ev(1'b1, n);
            chk(32'(n >= 22 && n <= 30), 32'h1);
            chk(32'(adc1_trigger_o), 32'h1);
            chk(32'(adc2_trigger_o), 32'h0);
            rreg(UPPER_COUNT_OFFSET, 32'h0);
         end
      end
      $display("test joined pair done");
      final_report();
   end

   // Watchdog well beyond the few thousand cycles the sequence needs.
   initial begin
      #100000;
      n_fail++;
      final_report();
   end
endmodule : pairable_timer_32bit_tb
